// ### rtl/psc_map.vh
// register offsets, reset values and field positions of the switch groups
`ifndef PSC_MAP_VH
`define PSC_MAP_VH
`define PSC_OFS_LATCH 12'h000
`define PSC_OFS_CURVE 12'h004
`define PSC_OFS_INPUT 12'h008
`define PSC_OFS_CLEAR 12'h00c
`define PSC_OFS_STATUS 12'h010
`define PSC_OFS_CURSEL 12'h014
`define PSC_RST_LATCH 8'haa
`define PSC_RST_CURVE 8'h00
`define PSC_RST_INPUT 8'h00
`define PSC_IN_CLR_IND 0
`define PSC_IN_UNLATCH 1
`define PSC_IN_CLR_ALL 2
`define PSC_IN_GROUP 3
`define PSC_IN_BLOCK0 4
`define PSC_CUR_DT 2'h0
`define PSC_CUR_A 2'h1
`define PSC_CUR_B 2'h2
`define PSC_CUR_C 2'h3
`endif

// ### rtl/psc_switchgroup.v
// switch group registers and indication, blocking and group logic
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ns
`include "psc_map.vh"
// Notes on behaviour
// - start latch bit 0 self-clears when fault goes; 1 holds start.
// - trip latch bit 0 self-clears after fault; 1 holds trip indication.
// - latch bit pairs per stage: start even bit, trip odd bit.
// - latch group resets to 170: trips latch, starts self-clear.
// - curve bits pick A/B for overvoltage, C for undervoltage, else definite.
// - both overvoltage curve bits set: lowest weight bit wins.
// - input option bit 1 lets the binary input clear indications.
// - option bit 2 clears indications and unlatches output contacts.
// - option bit 3 clears indications, memories, and unlatches contacts.
// - option bit 4: energized input selects group 2, else group 1.
// - option bits 5 to 8 let the energized input block stage trip.
module psc_switchgroup (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire external_binary_input,
   input wire [3:0] stage_start,
   input wire [3:0] stage_trip,
   output reg [3:0] start_indication,
   output reg [3:0] trip_indication,
   output reg [3:0] trip_out,
   output reg [7:0] curve_sel,
   output reg setting_group2,
   output reg unlatch_contacts,
   output reg clear_memory
);
   reg [7:0] indication_latch_config;
   reg [7:0] time_curve_select;
   reg [7:0] input_action_config;
   reg bi_meta;
   reg bi_sync;
   reg bi_prev;
   reg sw_clear;
   reg [1:0] next_curve [0:3];
   reg [7:0] next_curve_sel;
   reg [31:0] next_prdata;
   reg next_err;
   wire bi_rise;
   wire bi_clear;
   wire ind_clear;
   wire acc;
   wire bi_unlatch;
   wire bi_memory;
   wire group_follow;
   wire next_ready;
   reg [3:0] next_start;
   reg [3:0] next_trip;
   reg [3:0] next_trip_out;
   reg next_group2;

   assign acc = psel && penable;
   // single clear per input assertion
   assign bi_rise = bi_sync && !bi_prev;
   assign bi_clear = bi_rise && (input_action_config[`PSC_IN_CLR_IND] ||
      input_action_config[`PSC_IN_UNLATCH] ||
      input_action_config[`PSC_IN_CLR_ALL]);
   assign ind_clear = bi_clear || sw_clear;

   // option bit actions: unlatch and memory on an input edge, group follow on level
   assign bi_unlatch = bi_rise && (input_action_config[`PSC_IN_UNLATCH] ||
      input_action_config[`PSC_IN_CLR_ALL]);
   assign bi_memory = bi_rise &&
      input_action_config[`PSC_IN_CLR_ALL];
   assign group_follow = input_action_config[`PSC_IN_GROUP];
   // answer one cycle after setup
   assign next_ready = psel && !penable;

   // two flip-flop synchroniser for the field input
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bi_meta <= 1'b0;
         bi_sync <= 1'b0;
      end else begin
         bi_meta <= external_binary_input;
         bi_sync <= bi_meta;
      end
   end

   // previous synchronised level for edge detection
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bi_prev <= 1'b0;
      end else begin
         bi_prev <= bi_sync;
      end
   end

   // indication latch mode group
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         indication_latch_config <= `PSC_RST_LATCH;
      end else if (acc && pwrite) begin
         if (paddr == `PSC_OFS_LATCH) begin
            indication_latch_config <= pwdata[7:0];
         end
      end
   end

   // time characteristic group
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         time_curve_select <= `PSC_RST_CURVE;
      end else if (acc && pwrite) begin
         if (paddr == `PSC_OFS_CURVE) begin
            time_curve_select <= pwdata[7:0];
         end
      end
   end

   // binary input option group
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_action_config <= `PSC_RST_INPUT;
      end else if (acc && pwrite) begin
         if (paddr == `PSC_OFS_INPUT) begin
            input_action_config <= pwdata[7:0];
         end
      end
   end

   // software clear strobe, one cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_clear <= 1'b0;
      end else begin
         sw_clear <= 1'b0;
         if (acc && pwrite) begin
            if (paddr == `PSC_OFS_CLEAR) begin
               sw_clear <= pwdata[0];
            end
         end
      end
   end

   // curve selection per stage
   always @* begin
      next_curve[0] = `PSC_CUR_DT;
      next_curve[1] = `PSC_CUR_DT;
      next_curve[2] = `PSC_CUR_DT;
      next_curve[3] = `PSC_CUR_DT;
      // overvoltage pairs, lowest weight wins
      if (time_curve_select[0]) begin
         next_curve[0] = `PSC_CUR_A;
      end else if (time_curve_select[1]) begin
         next_curve[0] = `PSC_CUR_B;
      end
      if (time_curve_select[2]) begin
         next_curve[1] = `PSC_CUR_A;
      end else if (time_curve_select[3]) begin
         next_curve[1] = `PSC_CUR_B;
      end
      // undervoltage stages, one bit each
      if (time_curve_select[4]) begin
         next_curve[2] = `PSC_CUR_C;
      end
      if (time_curve_select[5]) begin
         next_curve[3] = `PSC_CUR_C;
      end
      next_curve_sel = {next_curve[3], next_curve[2], next_curve[1],
         next_curve[0]};
   end

   // read mux
   always @* begin
      next_prdata = 32'h0000_0000;
      next_err = 1'b0;
      if (paddr == `PSC_OFS_LATCH) begin
         next_prdata = {24'h00_0000, indication_latch_config};
      end else if (paddr == `PSC_OFS_CURVE) begin
         next_prdata = {24'h00_0000, time_curve_select};
      end else if (paddr == `PSC_OFS_INPUT) begin
         next_prdata = {24'h00_0000, input_action_config};
      end else if (paddr == `PSC_OFS_CLEAR) begin
         next_prdata = 32'h0000_0000;
      end else if (paddr == `PSC_OFS_STATUS) begin
         // status: start, trip, trip out, group, input
         next_prdata = {18'h0_0000, bi_sync, setting_group2, trip_out,
            trip_indication, start_indication};
      end else if (paddr == `PSC_OFS_CURSEL) begin
         next_prdata = {24'h00_0000, curve_sel};
      end else begin
         next_err = 1'b1;
      end
   end

   // apb answer, zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= next_ready;
         pslverr <= next_ready && next_err;
      end
   end

   // read data taken from the setup cycle address
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= next_prdata;
      end
   end

   // curve choice per stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         curve_sel <= 8'h00;
      end else begin
         curve_sel <= next_curve_sel;
      end
   end

   // active setting group, held while not following
   always @* begin
      next_group2 = setting_group2;
      if (group_follow) begin
         next_group2 = bi_sync;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setting_group2 <= 1'b0;
      end else begin
         setting_group2 <= next_group2;
      end
   end

   // contact release and memory clear pulses
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlatch_contacts <= 1'b0;
         clear_memory <= 1'b0;
      end else begin
         unlatch_contacts <= bi_unlatch;
         clear_memory <= bi_memory;
      end
   end

   // per stage indications and trip blocking
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : stage
         // latch bits 2g and 2g+1
         wire start_hold;
         wire trip_hold;
         wire trip_block;
         assign start_hold = indication_latch_config[2*g];
         assign trip_hold = indication_latch_config[2*g+1];
         assign trip_block = bi_sync && input_action_config[`PSC_IN_BLOCK0+g];

         // set wins over a clear in the same cycle
         always @* begin
            next_start[g] = start_indication[g];
            if (stage_start[g]) begin
               next_start[g] = 1'b1;
            end else if (!start_hold || ind_clear) begin
               next_start[g] = 1'b0;
            end
         end

         // trip indication, same set and clear order
         always @* begin
            next_trip[g] = trip_indication[g];
            if (stage_trip[g]) begin
               next_trip[g] = 1'b1;
            end else if (!trip_hold || ind_clear) begin
               next_trip[g] = 1'b0;
            end
         end

         // trip suppressed while the input is energized and the stage's block option bit is set
         always @* begin
            next_trip_out[g] = stage_trip[g] && !trip_block;
         end

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               start_indication[g] <= 1'b0;
               trip_indication[g] <= 1'b0;
               trip_out[g] <= 1'b0;
            end else begin
               start_indication[g] <= next_start[g];
               trip_indication[g] <= next_trip[g];
               trip_out[g] <= next_trip_out[g];
            end
         end
      end
   endgenerate
endmodule

// ### verification/psc_props.sv
// port checker for the switch group block
`timescale 1ns/1ns
module psc_props (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire [3:0] stage_start,
   input wire [3:0] stage_trip,
   input wire [3:0] start_indication,
   input wire [3:0] trip_out,
   input wire unlatch_contacts,
   input wire clear_memory
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable && pready; endsequence
   a_ready_access: assert property (s_setup |=> s_access)
      else $error("no ready in access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_start_follow: assert property (|stage_start |=>
      (start_indication & $past(stage_start)) == $past(stage_start))
      else $error("start indication missed");
   a_trip_pass: assert property (1 |=>
      (trip_out & ~$past(stage_trip)) == 4'h0)
      else $error("trip out without stage trip");
   a_unlatch_once: assert property
      (unlatch_contacts |=> !unlatch_contacts)
      else $error("unlatch pulse too long");
   a_memory_once: assert property (clear_memory |=> !clear_memory)
      else $error("memory clear pulse too long");
   a_memory_unlatch: assert property
      (clear_memory |-> unlatch_contacts)
      else $error("memory clear without unlatch");
endmodule
bind psc_switchgroup psc_props u_props (.pclk, .presetn, .psel, .penable,
   .pready, .pslverr, .stage_start, .stage_trip, .start_indication,
   .trip_out, .unlatch_contacts, .clear_memory);

// ### verification/psc_field_src.sv
// field binary input source
`timescale 1ns/1ns
module psc_field_src (
   input wire pclk,
   input wire level,
   output reg external_binary_input = 1'b0
);
   always @(posedge pclk) external_binary_input <= level;
endmodule

// ### verification/tb.sv
// self-checking bench for the switch group block
`timescale 1ns/1ns
module tb;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lvl = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, lf = 32'h162e_018b;
   reg [3:0] stage_start = 0, stage_trip = 0;
   wire [31:0] prdata;
   wire pready, pslverr, external_binary_input, setting_group2;
   wire unlatch_contacts, clear_memory;
   wire [3:0] start_indication, trip_indication, trip_out;
   wire [7:0] curve_sel;
   integer mismatches = 0, checked = 0, cyc = 0, nu = 0, nm = 0, k;
   reg [32:0] q[$];
   reg [32:0] e;
   always #5 pclk = ~pclk;
   psc_switchgroup DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .external_binary_input,
      .stage_start, .stage_trip, .start_indication, .trip_indication,
      .trip_out, .curve_sel, .setting_group2, .unlatch_contacts,
      .clear_memory);
   psc_field_src field (.pclk, .level(lvl), .external_binary_input);
   function [31:0] nx(input [31:0] v);
      nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function [7:0] cv(input [7:0] v);
      cv = {v[5] ? 2'h3 : 2'h0, v[4] ? 2'h3 : 2'h0,
         v[2] ? 2'h1 : {v[3], 1'b0}, v[0] ? 2'h1 : {v[1], 1'b0}};
   endfunction
   task chk(input string n, input [31:0] x, input [31:0] g);
      begin
         checked = checked + 1;
         if (g !== x) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", n, x, g);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checked %0d mismatches %0d", checked, mismatches);
         if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d, input [32:0] x);
      begin
         @(posedge pclk);
         psel <= 1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         if (!w) q.push_back(x);
         @(posedge pclk) penable <= 1;
         @(posedge pclk);
         while (!pready) @(posedge pclk);
         psel <= 0;
         penable <= 0;
      end
   endtask
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (unlatch_contacts) nu = nu + 1;
      if (clear_memory) nm = nm + 1;
      if (psel && penable && pready && !pwrite) begin
         e = q.pop_front();
         chk("read data", e[31:0], prdata);
         chk("slave error", {31'h0, e[32]}, {31'h0, pslverr});
      end
      if (cyc == 3000) begin
         mismatches = mismatches + 1;
         give_verdict;
      end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      apb(0, 12'h000, 0, {1'b0, 32'h0000_00aa});
      apb(0, 12'h004, 0, 0);
      apb(0, 12'h008, 0, 0);
      apb(0, 12'h018, 0, {1'b1, 32'h0000_0000});
      for (k = 0; k < 6; k = k + 1) begin
         lf = nx(lf);
         apb(1, 12'h000, lf, 0);
         apb(0, 12'h000, 0, {25'h0, lf[7:0]});
         apb(1, 12'h004, lf, 0);
         apb(0, 12'h014, 0, {25'h0, cv(lf[7:0])});
         chk("curve select", {24'h0, cv(lf[7:0])},
            {24'h0, curve_sel});
      end
      $display("registers and curves done");
      apb(1, 12'h000, 32'h0000_0002, 0);
      for (k = 0; k < 3; k = k + 1) begin
         apb(1, 12'h008, 32'h0000_0001 << k, 0);
         stage_start <= 4'h1;
         stage_trip <= 4'h1;
         @(posedge pclk);
         stage_start <= 4'h0;
         stage_trip <= 4'h0;
         repeat (2) @(posedge pclk);
         apb(0, 12'h010, 0, 33'h0_0000_0010);
         nu = 0;
         nm = 0;
         lvl <= 1;
         repeat (8) @(posedge pclk);
         apb(0, 12'h010, 0, 33'h0_0000_2000);
         lvl <= 0;
         repeat (4) @(posedge pclk);
         chk("unlatch pulses", k > 0, nu);
         chk("memory pulses", k == 2, nm);
      end
      $display("binary input clears done");
      apb(1, 12'h000, 32'h0000_0055, 0);
      apb(1, 12'h008, 32'h0000_0000, 0);
      stage_start <= 4'hf;
      stage_trip <= 4'hf;
      @(posedge pclk);
      stage_start <= 4'h0;
      stage_trip <= 4'h0;
      lvl <= 1;
      repeat (8) @(posedge pclk);
      apb(0, 12'h010, 0, 33'h0_0000_200f);
      lvl <= 0;
      repeat (4) @(posedge pclk);
      apb(1, 12'h00c, 32'h0000_0001, 0);
      apb(0, 12'h010, 0, 33'h0_0000_0000);
      $display("latch modes and software clear done");
      apb(1, 12'h008, 32'h0000_0018, 0);
      stage_trip <= 4'h3;
      lvl <= 1;
      repeat (6) @(posedge pclk);
      chk("group", 1, {31'h0, setting_group2});
      chk("trip out", 2, {28'h0, trip_out});
      lvl <= 0;
      repeat (6) @(posedge pclk);
      chk("group", 0, {31'h0, setting_group2});
      apb(1, 12'h008, 0, 0);
      lvl <= 1;
      repeat (6) @(posedge pclk);
      chk("group", 0, {31'h0, setting_group2});
      chk("trip out", 3, {28'h0, trip_out});
      apb(1, 12'h008, 32'h0000_00e0, 0);
      stage_trip <= 4'hf;
      repeat (3) @(posedge pclk);
      chk("trip out", 1, {28'h0, trip_out});
      $display("group and blocking done");
      give_verdict;
   end
endmodule
